// [rtl/ccpm_pkg.sv]
// constants and register map of the cpu clock source and power mode block
// What this block does
// - after reset the cpu runs from the crystal, not the ring
// - source select 1 picks crystal, 0 picks ring, independent of divider
// - read-only ring active bit is 1 while ring clocks cpu, resets 0
// - amp disable stops crystal amp, settable only while source select is 0
// - source change takes effect one instruction cycle after the write
// - clearing amp disable restarts warm-up; stable after 65536 crystal clocks
// - select 0-to-1 refused unless crystal stable and amp disable is 0
// - switchback restores only the divider, never the clock source
// - divider 01 is 4 clocks, 10 is 64, 11 is 1024; resets 01
// - divider 10 or 11 accepted only while divider holds 01
// - switchback enable, unrestricted, reset 0, lets hardware force divider to 01
// - three read-only in-service bits for power-fail, high and low priority
// - four read-only serial activity bits, port1 tx highest, port0 rx lowest
// - power control bit 0 enters idle; any interrupt or reset ends it
// - power control bit 1 enters stop; only external interrupt, power-fail warning with bandgap in stop, or reset ends it
// - bandgap in stop keeps reference on in stop so power-fail can wake
// - ring wake select 1 resumes from stop at once on the ring
// - after ring wake, switch to crystal after 65536 crystal clocks, clear ring active
// - switchback on serviceable external irq, serial start bit, or tx buffer write
package ccpm_pkg;
  // register indices as printed; byte address is four times the index
  localparam logic [7:0]  IDX_POWER_CONTROL = 8'h87;
  localparam logic [7:0]  IDX_EXT_FLAG_CLK  = 8'h91;
  localparam logic [7:0]  IDX_POWER_MGMT    = 8'hc4;
  localparam logic [7:0]  IDX_POWER_STATUS  = 8'hc5;
  localparam logic [11:0] ADDR_POWER_CONTROL = {2'h0, IDX_POWER_CONTROL, 2'h0};
  localparam logic [11:0] ADDR_EXT_FLAG_CLK  = {2'h0, IDX_EXT_FLAG_CLK, 2'h0};
  localparam logic [11:0] ADDR_POWER_MGMT    = {2'h0, IDX_POWER_MGMT, 2'h0};
  localparam logic [11:0] ADDR_POWER_STATUS  = {2'h0, IDX_POWER_STATUS, 2'h0};
  // field positions
  localparam int PC_IDLE    = 0;
  localparam int PC_STOP    = 1;
  localparam int EX_BGS     = 0;
  localparam int EX_RWAKE   = 1;
  localparam int EX_RING    = 2;
  localparam int EX_SRC     = 3;
  localparam int PM_AMPOFF  = 3;
  localparam int PM_SWB     = 5;
  localparam int PM_DIV_LO  = 6;
  // divider encodings
  localparam logic [1:0] DIV_4    = 2'h1;
  localparam logic [1:0] DIV_64   = 2'h2;
  localparam logic [1:0] DIV_1024 = 2'h3;
  // reset values
  localparam logic [1:0] RST_DIV    = DIV_4;
  localparam logic       RST_SRC    = 1'h1;
  localparam logic       RST_STABLE = 1'h1;
  // crystal warm-up length in crystal clocks
  localparam int WARMUP_XTAL_CLOCKS = 65536;
  // instruction cycle lengths in core clocks, minus one
  localparam logic [10:0] CYC_4    = 11'h003;
  localparam logic [10:0] CYC_64   = 11'h03f;
  localparam logic [10:0] CYC_1024 = 11'h3ff;
  // power states
  typedef enum logic [1:0] {
    CCPM_RUN  = 2'b00,
    CCPM_IDLE = 2'b01,
    CCPM_STOP = 2'b10,
    CCPM_WAKE = 2'b11
  } ccpm_state_t;
endpackage : ccpm_pkg

// [rtl/ccpm_clock_power.sv]
// cpu clock source, cycle divider and idle/stop control with apb registers
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/100ps
module ccpm_clock_power #(
  parameter int WARMUP = ccpm_pkg::WARMUP_XTAL_CLOCKS
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // pins, asynchronous
  input  wire logic        xtal_clk_pin,
  input  wire logic        xtal_osc_ok_pin,
  input  wire logic        ext_irq_pin,
  // core events, same clock
  input  wire logic        ext_irq_serviceable,
  input  wire logic        any_irq,
  input  wire logic        early_power_warn_irq,
  input  wire logic        serial_start_bit,
  input  wire logic        serial_tx_write,
  // core status, same clock
  input  wire logic        powerfail_irq_in_service,
  input  wire logic        high_prio_in_service,
  input  wire logic        low_prio_in_service,
  input  wire logic        port1_tx_active,
  input  wire logic        port1_rx_active,
  input  wire logic        port0_tx_active,
  input  wire logic        port0_rx_active,
  // clock and power controls
  output logic             ring_active,
  output logic [1:0]       cycle_divider,
  output logic             xtal_amp_on,
  output logic             cpu_halted,
  output logic             clocks_off,
  output logic             bandgap_on
);
  import ccpm_pkg::*;

  // instruction cycle length for a divider code
  function automatic logic [10:0] cyc_len(input logic [1:0] d);
    case (d)
      DIV_64:   cyc_len = CYC_64;
      DIV_1024: cyc_len = CYC_1024;
      default:  cyc_len = CYC_4;
    endcase
  endfunction : cyc_len

  // state registers
  ccpm_state_t state;
  logic        clock_source_select;
  logic        crystal_amp_disable;
  logic        auto_restore_enable;
  logic        crystal_stable;
  logic        bandgap_in_stop;
  logic        ring_wake_select;
  logic        ring_wake_pending;
  logic [1:0]  power_control_bits;
  logic [16:0] warm_cnt;
  logic [10:0] sel_cnt;
  logic [2:0]  xclk_sync;
  logic [1:0]  osc_sync;
  logic [1:0]  irq_sync;

  // two-flop synchronisers; edge detect uses only the second stage onward
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      xclk_sync <= 3'h0;
      osc_sync  <= 2'h0;
      irq_sync  <= 2'h0;
    end else begin
      xclk_sync <= {xclk_sync[1:0], xtal_clk_pin};
      osc_sync  <= {osc_sync[0], xtal_osc_ok_pin};
      irq_sync  <= {irq_sync[0], ext_irq_pin};
    end
  end

  wire xtal_tick = xclk_sync[1] & ~xclk_sync[2];
  wire osc_ok    = osc_sync[1];
  wire ext_irq   = irq_sync[1];

  // apb decode
  wire acc      = psel & penable & pready;
  wire wr       = acc & pwrite;
  wire hit_pc   = paddr == ADDR_POWER_CONTROL;
  wire hit_ex   = paddr == ADDR_EXT_FLAG_CLK;
  wire hit_pm   = paddr == ADDR_POWER_MGMT;
  wire hit_st   = paddr == ADDR_POWER_STATUS;
  wire mapped   = hit_pc | hit_ex | hit_pm | hit_st;
  wire wr_pc    = wr & hit_pc;
  wire wr_ex    = wr & hit_ex;
  wire wr_pm    = wr & hit_pm;

  // requested field values
  wire       req_src = pwdata[EX_SRC];
  wire       req_off = pwdata[PM_AMPOFF];
  wire [1:0] req_div = pwdata[PM_DIV_LO+1:PM_DIV_LO];

  // access checks; refused writes leave the bit alone
  wire src_ok = ~req_src | clock_source_select |
                (crystal_stable & ~crystal_amp_disable);
  wire off_ok = ~req_off | ~clock_source_select;
  wire div_ok = (req_div == DIV_4) |
                ((req_div != 2'h0) & (cycle_divider == DIV_4));

  // switchback triggers
  wire swb_event = auto_restore_enable &
                   ((ext_irq & ext_irq_serviceable) | serial_start_bit | serial_tx_write);

  // stop wake sources
  wire stop_wake = ext_irq | (bandgap_in_stop & early_power_warn_irq);

  // amplifier runs unless disabled or in stop
  wire amp_run   = ~crystal_amp_disable & (state != CCPM_STOP);
  wire warm_done = warm_cnt == 17'(WARMUP - 1);

  // next state of the power state machine
  ccpm_state_t next_state;
  always_comb begin
    next_state = state;
    case (state)
      CCPM_RUN: begin
        if (wr_pc & pwdata[PC_STOP])
          next_state = CCPM_STOP;
        else if (wr_pc & pwdata[PC_IDLE])
          next_state = CCPM_IDLE;
      end
      CCPM_IDLE: begin
        if (any_irq)
          next_state = CCPM_RUN;
      end
      CCPM_STOP: begin
        if (stop_wake)
          next_state = ring_wake_select ? CCPM_RUN : CCPM_WAKE;
      end
      CCPM_WAKE: begin
        if (crystal_stable)
          next_state = CCPM_RUN;
      end
      default: next_state = CCPM_RUN;
    endcase
  end

  wire ring_wake = (state == CCPM_STOP) & stop_wake & ring_wake_select;

  // power state and power control bits, which clear on exit
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state     <= CCPM_RUN;
      power_control_bits <= 2'h0;
    end else begin
      state     <= next_state;
      power_control_bits <= (next_state == CCPM_RUN) ? 2'h0 :
                   (wr_pc ? pwdata[1:0] : power_control_bits);
    end
  end

  // software-written control bits with their access checks
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      clock_source_select <= RST_SRC;
      crystal_amp_disable <= 1'h0;
      auto_restore_enable <= 1'h0;
      bandgap_in_stop     <= 1'h0;
      ring_wake_select    <= 1'h0;
    end else begin
      if (ring_wake_pending & crystal_stable)
        clock_source_select <= 1'h1;
      else if (wr_ex & src_ok)
        clock_source_select <= req_src;
      if (wr_pm & off_ok)
        crystal_amp_disable <= req_off;
      if (wr_pm)
        auto_restore_enable <= pwdata[PM_SWB];
      if (wr_ex) begin
        bandgap_in_stop  <= pwdata[EX_BGS];
        ring_wake_select <= pwdata[EX_RWAKE];
      end
    end
  end

  // cycle divider; hardware switchback beats a software write
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst)
      cycle_divider <= RST_DIV;
    else if (swb_event)
      cycle_divider <= DIV_4;
    else if (wr_pm & div_ok)
      cycle_divider <= req_div;
  end

  // crystal warm-up: count crystal clocks after the oscillator starts
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      warm_cnt       <= 17'h0;
      crystal_stable <= RST_STABLE;
    end else if (~amp_run) begin
      warm_cnt       <= 17'h0;
      crystal_stable <= 1'h0;
    end else if (~crystal_stable & osc_ok & xtal_tick) begin
      warm_cnt       <= warm_cnt + 17'h1;
      crystal_stable <= warm_done;
    end
  end

  // ring wake bookkeeping: back to crystal once it is stable
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst)
      ring_wake_pending <= 1'h0;
    else if (ring_wake)
      ring_wake_pending <= 1'h1;
    else if (crystal_stable | state == CCPM_STOP)
      ring_wake_pending <= 1'h0;
  end

  // source change waits one instruction cycle of the current divider;
  // compare is >= so a divider drop mid-count cannot strand the counter
  // a ring wake keeps the ring until the crystal is stable
  wire ring_hold   = ring_wake_pending & ~crystal_stable;
  wire src_differs = clock_source_select == ring_active;
  wire sel_due     = sel_cnt >= cyc_len(cycle_divider);
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst)
      sel_cnt <= 11'h0;
    else if (~src_differs | ring_wake | ring_hold | sel_due)
      sel_cnt <= 11'h0;
    else
      sel_cnt <= sel_cnt + 11'h1;
  end

  // active source; ring wake forces ring at once
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst)
      ring_active <= 1'h0;
    else if (ring_wake)
      ring_active <= 1'h1;
    else if (src_differs & sel_due)
      ring_active <= ~clock_source_select;
  end

  // power outputs, all registered
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      xtal_amp_on <= 1'h1;
      cpu_halted  <= 1'h0;
      clocks_off  <= 1'h0;
      bandgap_on  <= 1'h1;
    end else begin
      xtal_amp_on <= ~crystal_amp_disable & (next_state != CCPM_STOP);
      cpu_halted  <= next_state != CCPM_RUN;
      clocks_off  <= next_state == CCPM_STOP | next_state == CCPM_WAKE;
      bandgap_on  <= next_state != CCPM_STOP | bandgap_in_stop;
    end
  end

  // read mux
  wire [7:0] rd_pc = {6'h0, power_control_bits};
  wire [7:0] rd_ex = {4'h0, clock_source_select, ring_active, ring_wake_select, bandgap_in_stop};
  wire [7:0] rd_pm = {cycle_divider, auto_restore_enable, 1'h0, crystal_amp_disable, 3'h0};
  wire [7:0] rd_st = {powerfail_irq_in_service, high_prio_in_service, low_prio_in_service,
                      crystal_stable, port1_tx_active, port1_rx_active,
                      port0_tx_active, port0_rx_active};
  wire [7:0] rd_val = hit_pc ? rd_pc : hit_ex ? rd_ex : hit_pm ? rd_pm : hit_st ? rd_st : 8'h0;

  // apb answer one cycle into the access phase
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pready  <= 1'h0;
      prdata  <= 32'h0;
      pslverr <= 1'h0;
    end else begin
      pready  <= psel & penable & ~pready;
      prdata  <= (psel & penable & ~pready & ~pwrite) ? {24'h0, rd_val} : 32'h0;
      pslverr <= psel & penable & ~pready & ~mapped;
    end
  end

  // helper: divider request written on the previous cycle was refused
  logic div_refused;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst)
      div_refused <= 1'h0;
    else
      div_refused <= wr_pm & ~div_ok & ~swb_event;
  end

  // helper: cycles that ring_active has lagged the select outside a ring wake;
  // saturates so a stuck source cannot wrap back under the bound
  logic [10:0] lag_cnt;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst)
      lag_cnt <= 11'h0;
    else if (~src_differs | ring_wake | ring_wake_pending)
      lag_cnt <= 11'h0;
    else if (lag_cnt != 11'h7ff)
      lag_cnt <= lag_cnt + 11'h1;
  end

  // checks
  sequence s_src_write;
    wr_ex & req_src & ~clock_source_select & src_ok & (state == CCPM_RUN);
  endsequence

  sequence s_idle_write;
    wr_pc & pwdata[PC_IDLE] & ~pwdata[PC_STOP] & (state == CCPM_RUN);
  endsequence

  a_rst_crystal: assert property (@(posedge core_clk)
    $fell(sys_rst) |-> ~ring_active & clock_source_select)
    else $error("not on crystal after reset");
  a_ring_tracks: assert property (@(posedge core_clk) disable iff (sys_rst)
    lag_cnt < 11'h406)
    else $error("ring active never follows select");
  a_amp_guard: assert property (@(posedge core_clk) disable iff (sys_rst)
    $rose(crystal_amp_disable) |-> $past(~clock_source_select))
    else $error("amp disabled while crystal selected");
  a_src_delay: assert property (@(posedge core_clk) disable iff (sys_rst)
    (s_src_write ##1 (cycle_divider == DIV_4)[*5]) |-> ~ring_active)
    else $error("crystal not taken one cycle later");
  a_src_guard: assert property (@(posedge core_clk) disable iff (sys_rst)
    ($rose(clock_source_select) & ~$past(ring_wake_pending)) |->
      $past(crystal_stable & ~crystal_amp_disable))
    else $error("select set before crystal stable");
  a_stable_clear: assert property (@(posedge core_clk) disable iff (sys_rst)
    crystal_amp_disable |=> ~crystal_stable)
    else $error("stable while amp off");
  a_stable_count: assert property (@(posedge core_clk) disable iff (sys_rst)
    $rose(crystal_stable) |-> $past(osc_ok & xtal_tick & warm_done))
    else $error("stable without full warm-up");
  a_swb_div: assert property (@(posedge core_clk) disable iff (sys_rst)
    swb_event |=> (cycle_divider == DIV_4) & $stable(clock_source_select))
    else $error("switchback wrong");
  a_swb_none: assert property (@(posedge core_clk) disable iff (sys_rst)
    (~auto_restore_enable & ~wr_pm) |=> $stable(cycle_divider))
    else $error("divider moved with switchback off");
  a_div_guard: assert property (@(posedge core_clk) disable iff (sys_rst)
    div_refused |-> $stable(cycle_divider))
    else $error("refused divider write took effect");

  // power state sequencing
  a_idle_entry: assert property (@(posedge core_clk) disable iff (sys_rst)
    s_idle_write |=> (state == CCPM_IDLE) & cpu_halted)
    else $error("idle not entered");
  a_idle_exit: assert property (@(posedge core_clk) disable iff (sys_rst)
    (state == CCPM_IDLE & any_irq) |=> ##1 ~cpu_halted)
    else $error("idle not ended by interrupt");
  a_power_control_clear: assert property (@(posedge core_clk) disable iff (sys_rst)
    ((state != CCPM_RUN) & (next_state == CCPM_RUN)) |=> (power_control_bits == 2'h0))
    else $error("power control bits kept after exit");
  a_stop_amp: assert property (@(posedge core_clk) disable iff (sys_rst)
    (state == CCPM_STOP) |-> ~xtal_amp_on)
    else $error("amp running in stop");
  a_stop_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
    ((state == CCPM_STOP) & ~stop_wake) |=> (state == CCPM_STOP))
    else $error("stop left without wake source");
  a_bgs_off: assert property (@(posedge core_clk) disable iff (sys_rst)
    (next_state == CCPM_STOP & ~bandgap_in_stop) |=> ~bandgap_on)
    else $error("bandgap on in stop");
  a_bgs_keep: assert property (@(posedge core_clk) disable iff (sys_rst)
    ((next_state == CCPM_STOP) & bandgap_in_stop) |=> bandgap_on)
    else $error("bandgap off in stop");
  a_ring_wake: assert property (@(posedge core_clk) disable iff (sys_rst)
    ring_wake |=> ring_active & (state == CCPM_RUN))
    else $error("ring wake not immediate");
  a_wake_wait: assert property (@(posedge core_clk) disable iff (sys_rst)
    ((state == CCPM_WAKE) & ~crystal_stable) |=> cpu_halted & clocks_off)
    else $error("woke before crystal stable");
  a_ring_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
    ring_hold |=> ring_active)
    else $error("ring dropped before crystal stable");
  a_ring_back: assert property (@(posedge core_clk) disable iff (sys_rst)
    (ring_wake_pending & crystal_stable) |=> clock_source_select)
    else $error("no return to crystal");
endmodule : ccpm_clock_power

// [verification/tb.sv]
// self-checking bench for the cpu clock source and power mode block
`timescale 1ns/100ps
module tb;
  import ccpm_pkg::*;
  localparam int WARM = 8;
  // clock, reset and apb
  logic        core_clk, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        er;
  // pins, events and status inputs
  logic        xtal_clk_pin, xtal_osc_ok_pin, ext_irq_pin, ext_irq_serviceable, any_irq;
  logic        early_power_warn_irq, serial_start_bit, serial_tx_write;
  logic [6:0]  stat_in;
  // clock and power outputs
  logic        ring_active, xtal_amp_on, cpu_halted, clocks_off, bandgap_on;
  logic [1:0]  cycle_divider;
  int          n_fail, total_checks, cycles;
  logic [7:0]  dw [5] = '{8'h80, 8'hc0, 8'h40, 8'hc0, 8'h00};
  logic [7:0]  de [5] = '{8'h80, 8'h80, 8'h40, 8'hc0, 8'hc0};

  ccpm_clock_power #(.WARMUP(WARM)) DUT (
    .core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .xtal_clk_pin(xtal_clk_pin), .xtal_osc_ok_pin(xtal_osc_ok_pin), .ext_irq_pin(ext_irq_pin),
    .ext_irq_serviceable(ext_irq_serviceable), .any_irq(any_irq),
    .early_power_warn_irq(early_power_warn_irq), .serial_start_bit(serial_start_bit),
    .serial_tx_write(serial_tx_write), .powerfail_irq_in_service(stat_in[6]),
    .high_prio_in_service(stat_in[5]), .low_prio_in_service(stat_in[4]),
    .port1_tx_active(stat_in[3]), .port1_rx_active(stat_in[2]), .port0_tx_active(stat_in[1]),
    .port0_rx_active(stat_in[0]), .ring_active(ring_active), .cycle_divider(cycle_divider),
    .xtal_amp_on(xtal_amp_on), .cpu_halted(cpu_halted), .clocks_off(clocks_off),
    .bandgap_on(bandgap_on)
  );

  // core clock 100 ns; crystal pin kept well below half the core rate
  always #50 core_clk = ~core_clk;
  always #300 xtal_clk_pin = ~xtal_clk_pin;

  // hang guard: the whole run needs a few hundred cycles
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      end_sim();
    end
  end

  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // one apb transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    @(posedge core_clk);
    penable <= 1'b1;
    // no local limit: only the bench timeout ends a wait
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd      = prdata;
    er      = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rchk(input string nm, input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk(nm, {24'h0, e}, rd);
  endtask : rchk

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc

  // bounded wait for an output to reach a level
  task automatic wait_val(ref logic s, input logic v, input int n);
    for (int i = 0; i < n && s !== v; i++) @(posedge core_clk);
  endtask : wait_val

  initial begin
    {core_clk, xtal_clk_pin, psel, penable, pwrite, paddr, pwdata} = '0;
    {ext_irq_pin, ext_irq_serviceable, any_irq, early_power_warn_irq} = '0;
    {serial_start_bit, serial_tx_write, stat_in, n_fail, total_checks, cycles} = '0;
    xtal_osc_ok_pin = 1'b1;
    sys_rst         = 1'b1;
    cyc(16);
    sys_rst <= 1'b0;
    cyc(1);
    // reset state of outputs and registers
    chk("outs", 7'b0_01_1_001, {ring_active, cycle_divider, xtal_amp_on, cpu_halted, clocks_off, bandgap_on});
    rchk("ext_flag", ADDR_EXT_FLAG_CLK, 8'h08);
    rchk("pmgmt", ADDR_POWER_MGMT, 8'h40);
    rchk("status", ADDR_POWER_STATUS, 8'h10);
    rchk("pctl", ADDR_POWER_CONTROL, 8'h00);
    apb(1'b0, 12'h000, 8'h00);
    chk("slverr", 1, er);
    // status is read-only and mirrors the core levels
    apb(1'b1, ADDR_POWER_STATUS, 8'hff);
    stat_in <= 7'b1011001;
    rchk("status", ADDR_POWER_STATUS, 8'hb9);
    stat_in <= 7'b0100110;
    rchk("status", ADDR_POWER_STATUS, 8'h56);
    // divider encodings and the restriction on slow settings
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, ADDR_POWER_MGMT, dw[i]);
      rchk("pmgmt", ADDR_POWER_MGMT, de[i]);
      chk("divider", de[i][7:6], cycle_divider);
    end
    // hardware switchback for each trigger
    apb(1'b1, ADDR_POWER_MGMT, 8'h60);
    ext_irq_pin <= 1'b1; // request only counts while serviceable
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, ADDR_POWER_MGMT, 8'ha0);
      ext_irq_serviceable <= (i == 0);
      serial_start_bit    <= (i == 1);
      serial_tx_write     <= (i == 2);
      cyc(1);
      {ext_irq_serviceable, serial_start_bit, serial_tx_write} <= '0;
      cyc(2);
      chk("switchback", DIV_4, cycle_divider);
    end
    ext_irq_pin <= 1'b0;
    // no switchback while disabled
    apb(1'b1, ADDR_POWER_MGMT, 8'h40);
    apb(1'b1, ADDR_POWER_MGMT, 8'h80);
    serial_tx_write <= 1'b1;
    cyc(1);
    serial_tx_write <= 1'b0;
    cyc(2);
    chk("no_switchback", DIV_64, cycle_divider);
    apb(1'b1, ADDR_POWER_MGMT, 8'h40);
    // amp disable refused while on crystal
    apb(1'b1, ADDR_POWER_MGMT, 8'h48);
    rchk("pmgmt", ADDR_POWER_MGMT, 8'h40);
    chk("amp_on", 1, xtal_amp_on);
    // move to the ring: takes effect one instruction cycle later
    apb(1'b1, ADDR_EXT_FLAG_CLK, 8'h00);
    cyc(1);
    chk("ring_early", 0, ring_active);
    cyc(8);
    chk("ring_on", 1, ring_active);
    rchk("ext_flag", ADDR_EXT_FLAG_CLK, 8'h04);
    // switchback on the ring restores only the divider
    apb(1'b1, ADDR_POWER_MGMT, 8'ha0);
    serial_start_bit <= 1'b1;
    cyc(1);
    serial_start_bit <= 1'b0;
    cyc(2);
    chk("sb_src", {1'b1, DIV_4}, {ring_active, cycle_divider});
    // crystal off, then return to crystal in two steps
    apb(1'b1, ADDR_POWER_MGMT, 8'h68);
    cyc(2);
    chk("amp_off", 0, xtal_amp_on);
    apb(1'b1, ADDR_EXT_FLAG_CLK, 8'h08);
    rchk("ext_flag", ADDR_EXT_FLAG_CLK, 8'h04);
    apb(1'b1, ADDR_POWER_MGMT, 8'h60);
    apb(1'b1, ADDR_EXT_FLAG_CLK, 8'h08);
    rchk("ext_flag", ADDR_EXT_FLAG_CLK, 8'h04);
    chk("amp_back", 1, xtal_amp_on);
    for (int i = 0; i < 60 && rd[4] !== 1'b1; i++) apb(1'b0, ADDR_POWER_STATUS, 8'h00);
    chk("stable", 1, rd[4]);
    apb(1'b1, ADDR_EXT_FLAG_CLK, 8'h08);
    cyc(10);
    chk("ring_off", 0, ring_active);
    // idle ends on any interrupt
    apb(1'b1, ADDR_POWER_CONTROL, 8'h01);
    cyc(2);
    chk("idle", 2'b10, {cpu_halted, clocks_off});
    rchk("pctl", ADDR_POWER_CONTROL, 8'h01);
    any_irq <= 1'b1;
    cyc(1);
    any_irq <= 1'b0;
    wait_val(cpu_halted, 1'b0, 20);
    chk("idle_exit", 0, cpu_halted);
    // stop, woken by the pin, waits for the crystal
    apb(1'b1, ADDR_POWER_CONTROL, 8'h02);
    cyc(3);
    chk("stop", 4'b1100, {cpu_halted, clocks_off, bandgap_on, xtal_amp_on});
    any_irq <= 1'b1;
    cyc(4);
    any_irq <= 1'b0;
    chk("stop_hold", 1, cpu_halted);
    ext_irq_pin <= 1'b1;
    cyc(6);
    chk("wake_wait", 2'b11, {cpu_halted, clocks_off});
    wait_val(cpu_halted, 1'b0, 200);
    chk("wake", 2'b00, {cpu_halted, ring_active});
    ext_irq_pin <= 1'b0;
    // stop with reference kept on, woken by the power warning
    apb(1'b1, ADDR_EXT_FLAG_CLK, 8'h09);
    apb(1'b1, ADDR_POWER_CONTROL, 8'h02);
    cyc(3);
    chk("bandgap", 2'b11, {cpu_halted, bandgap_on});
    early_power_warn_irq <= 1'b1;
    wait_val(cpu_halted, 1'b0, 200);
    chk("pwarn_wake", 0, cpu_halted);
    early_power_warn_irq <= 1'b0;
    // stop with fast wake on the ring, then automatic return to crystal
    apb(1'b1, ADDR_EXT_FLAG_CLK, 8'h0a);
    apb(1'b1, ADDR_POWER_CONTROL, 8'h02);
    cyc(3);
    ext_irq_pin <= 1'b1;
    cyc(6);
    chk("ring_wake", 2'b01, {cpu_halted, ring_active});
    ext_irq_pin <= 1'b0;
    cyc(20);
    chk("ring_hold", 1, ring_active);
    wait_val(ring_active, 1'b0, 300);
    chk("ring_done", 0, ring_active);
    rchk("ext_flag", ADDR_EXT_FLAG_CLK, 8'h0a);
    end_sim();
  end
endmodule : tb
